//--- include/mic_regs.svh
`ifndef MIC_REGS_SVH
`define MIC_REGS_SVH
// byte offsets on the register bus
`define MIC_OFS_CONTROL 5'h00
`define MIC_OFS_PFLAG 5'h04
`define MIC_OFS_PENABLE 5'h08
`define MIC_OFS_OPTION 5'h0C
`define MIC_OFS_OSC 5'h10
`define MIC_OFS_STATUS 5'h14
// irq_control_reg fields
`define MIC_BIT_GLB_EN 7
`define MIC_BIT_GRP_EN 6
`define MIC_BIT_TMR_EN 5
`define MIC_BIT_EXT_EN 4
`define MIC_BIT_PORT_EN 3
`define MIC_BIT_TMR_FLAG 2
`define MIC_BIT_EXT_FLAG 1
`define MIC_BIT_PORT_FLAG 0
// peripheral flag / enable field, option field
`define MIC_BIT_ADC 0
`define MIC_BIT_EDGE 6
// reset values
`define MIC_RST_CONTROL 8'h00
`define MIC_RST_PFLAG 8'h00
`define MIC_RST_PENABLE 8'h00
`define MIC_RST_OPTION 8'hFF
// vector address and timing
`define MIC_VECTOR_ADDR 13'h0004
`define MIC_LAT_CYC 3
`define MIC_OST_TOSC 1024
`define MIC_TOSC_PER_CYC 4
`define MIC_OST_CYC (`MIC_OST_TOSC / `MIC_TOSC_PER_CYC)
`endif

//--- include/mic_pkg.sv
package mic_pkg;
  typedef enum logic [2:0] {
    MIC_OSC_LOWPWR,
    MIC_OSC_CRYSTAL,
    MIC_OSC_HISPEED,
    MIC_OSC_INT_RC,
    MIC_OSC_EXT_RC
  } mic_osc_t;

  typedef enum logic [1:0] {
    MIC_RUN,
    MIC_HALT,
    MIC_OST_WAIT
  } mic_pwr_t;

  typedef struct packed {
    logic [7:0] control;
    logic [7:0] pflag;
    logic [7:0] penable;
    logic [7:0] option;
    mic_osc_t osc;
    mic_pwr_t pwr;
    logic ext_en_at_halt;
    logic [8:0] ost_cnt;
    logic [1:0] lat_cnt;
    logic ext_prev;
    logic [2:0] port_prev;
    logic waitrequest;
    logic [31:0] readdata;
    logic irq_request;
    logic vector_take;
    logic push_stack;
    logic pc_load;
    logic [12:0] pc_vector;
    logic core_wake;
    logic halted;
  } mic_state_t;
endpackage

//--- rtl/mic_irq_ctrl.sv
`timescale 1ns/1ns
`include "mic_regs.svh"
// Overview of operation
// - four sources: timer overflow, external pin edge, port change, conversion done.
// - each flag sets on its event whatever the enables hold.
// - control bit 7 is the global enable; clear blocks all vectoring.
// - global enable plus any timer, external or port flag-and-enable pair requests the vector.
// - reset clears the global enable.
// - return-from-irq sets the global enable again.
// - on acceptance clear global enable, push return address, load 0004h.
// - conversion flag and enable live in peripheral registers, also group gated.
// - control bit 6 is the peripheral group enable.
// - event to vector takes three or four instruction cycles.
// - latency does not depend on one- or two-cycle instructions.
// - timer rollover sets control bit 2; bit 5 enables it.
// - option bit 6 set picks rising edges, clear picks falling.
// - valid external edge sets control bit 1; bit 4 enables it.
// - change on port pins 3, 1, 0 sets control bit 0; bit 3 enables.
// - external pin wakes from halt only if enabled before the halt.
// - after wake, vector if global enable set, else continue in line.
// - entry saves only the return address, nothing else.
// - crystal modes wait 1024 oscillator periods on wake; RC modes do not.
module mic_irq_ctrl
  import mic_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // event sources
  input wire logic timer_overflow,
  input wire logic conversion_done,
  input wire logic ext_irq_pin,
  input wire logic port_pin_zero,
  input wire logic port_pin_one,
  input wire logic port_pin_three,
  // core sequencer
  input wire logic return_from_irq,
  input wire logic halt_enter,
  output logic irq_request,
  output logic vector_take,
  output logic push_stack,
  output logic pc_load,
  output logic [12:0] pc_vector,
  output logic core_wake,
  output logic halted
);
  import mic_pkg::*;

  mic_state_t s_q;
  mic_state_t s_d;

  function automatic logic [7:0] mic_merge(input logic [7:0] old, input logic [31:0] wd,
                                           input logic be0);
    mic_merge = be0 ? wd[7:0] : old;
  endfunction

  function automatic logic mic_is_crystal(input mic_osc_t m);
    mic_is_crystal = (m == MIC_OSC_LOWPWR) || (m == MIC_OSC_CRYSTAL) || (m == MIC_OSC_HISPEED);
  endfunction

  logic ext_rise;
  logic ext_fall;
  logic ext_edge;
  logic port_change;
  logic bus_req;
  logic bus_done;
  logic periph_term;
  logic core_term;
  logic pend;
  logic [2:0] port_now;

  always_comb
  begin
    s_d = s_q;
    port_now = {port_pin_three, port_pin_one, port_pin_zero};
    ext_rise = ext_irq_pin && !s_q.ext_prev;
    ext_fall = !ext_irq_pin && s_q.ext_prev;
    ext_edge = s_q.option[`MIC_BIT_EDGE] ? ext_rise : ext_fall;
    port_change = (port_now != s_q.port_prev);
    bus_req = avs_read || avs_write;
    bus_done = bus_req && !s_q.waitrequest;
    s_d.ext_prev = ext_irq_pin;
    s_d.port_prev = port_now;

    // one wait cycle per access, then the answer is valid for one edge
    s_d.waitrequest = !(bus_req && s_q.waitrequest);
    if (bus_req && s_q.waitrequest)
    begin
      s_d.readdata = 32'h0000_0000;
      unique case (avs_address)
        `MIC_OFS_CONTROL: s_d.readdata[7:0] = s_q.control;
        `MIC_OFS_PFLAG: s_d.readdata[7:0] = s_q.pflag;
        `MIC_OFS_PENABLE: s_d.readdata[7:0] = s_q.penable;
        `MIC_OFS_OPTION: s_d.readdata[7:0] = s_q.option;
        `MIC_OFS_OSC: s_d.readdata[2:0] = s_q.osc;
        `MIC_OFS_STATUS: s_d.readdata[3:0] = {s_q.irq_request, s_q.pwr, s_q.ext_en_at_halt};
        default: s_d.readdata = 32'h0000_0000;
      endcase
    end

    if (bus_done && avs_write)
    begin
      unique case (avs_address)
        `MIC_OFS_CONTROL: s_d.control = mic_merge(s_q.control, avs_writedata, avs_byteenable[0]);
        `MIC_OFS_PFLAG: s_d.pflag = mic_merge(s_q.pflag, avs_writedata, avs_byteenable[0]);
        `MIC_OFS_PENABLE: s_d.penable = mic_merge(s_q.penable, avs_writedata, avs_byteenable[0]);
        `MIC_OFS_OPTION: s_d.option = mic_merge(s_q.option, avs_writedata, avs_byteenable[0]);
        `MIC_OFS_OSC:
        begin
          if (avs_byteenable[0] && (avs_writedata[2:0] <= 3'(MIC_OSC_EXT_RC)))
          begin
            s_d.osc = mic_osc_t'(avs_writedata[2:0]);
          end
        end
        default: s_d.osc = s_q.osc;
      endcase
    end

    // hardware sets follow software writes so a set in the clear cycle wins
    if (timer_overflow)
    begin
      s_d.control[`MIC_BIT_TMR_FLAG] = 1'b1;
    end
    if (ext_edge)
    begin
      s_d.control[`MIC_BIT_EXT_FLAG] = 1'b1;
    end
    if (port_change)
    begin
      s_d.control[`MIC_BIT_PORT_FLAG] = 1'b1;
    end
    if (conversion_done)
    begin
      s_d.pflag[`MIC_BIT_ADC] = 1'b1;
    end
    if (return_from_irq)
    begin
      s_d.control[`MIC_BIT_GLB_EN] = 1'b1;
    end

    periph_term = s_q.control[`MIC_BIT_GRP_EN]
                  && (s_q.pflag[`MIC_BIT_ADC] && s_q.penable[`MIC_BIT_ADC]);
    core_term = (s_q.control[`MIC_BIT_TMR_FLAG] && s_q.control[`MIC_BIT_TMR_EN])
                || (s_q.control[`MIC_BIT_EXT_FLAG] && s_q.control[`MIC_BIT_EXT_EN])
                || (s_q.control[`MIC_BIT_PORT_FLAG] && s_q.control[`MIC_BIT_PORT_EN]);
    pend = s_q.control[`MIC_BIT_GLB_EN] && (core_term || periph_term);

    s_d.vector_take = 1'b0;
    s_d.push_stack = 1'b0;
    s_d.pc_load = 1'b0;
    s_d.core_wake = 1'b0;
    s_d.irq_request = pend && (s_q.pwr == MIC_RUN);

    // latency counted in instruction cycles, never waiting on an instruction end
    if (pend && (s_q.pwr == MIC_RUN))
    begin
      if (s_q.lat_cnt == 2'(`MIC_LAT_CYC - 1))
      begin
        s_d.lat_cnt = 2'h0;
        s_d.vector_take = 1'b1;
        s_d.push_stack = 1'b1;
        s_d.pc_load = 1'b1;
        s_d.control[`MIC_BIT_GLB_EN] = 1'b0;
        s_d.irq_request = 1'b0;
      end
      else
      begin
        s_d.lat_cnt = s_q.lat_cnt + 2'h1;
      end
    end
    else
    begin
      s_d.lat_cnt = 2'h0;
    end
    // flags are left set on entry; the service routine must clear them

    unique case (s_q.pwr)
      MIC_RUN:
      begin
        if (halt_enter)
        begin
          s_d.pwr = MIC_HALT;
          s_d.ext_en_at_halt = s_q.control[`MIC_BIT_EXT_EN];
        end
      end
      MIC_HALT:
      begin
        if (s_q.ext_en_at_halt && s_q.control[`MIC_BIT_EXT_FLAG])
        begin
          if (mic_is_crystal(s_q.osc))
          begin
            s_d.pwr = MIC_OST_WAIT;
            s_d.ost_cnt = 9'h000;
          end
          else
          begin
            s_d.pwr = MIC_RUN;
            s_d.core_wake = 1'b1;
          end
        end
      end
      MIC_OST_WAIT:
      begin
        if (s_q.ost_cnt == 9'(`MIC_OST_CYC - 1))
        begin
          s_d.pwr = MIC_RUN;
          s_d.core_wake = 1'b1;
        end
        else
        begin
          s_d.ost_cnt = s_q.ost_cnt + 9'h001;
        end
      end
      default: s_d.pwr = MIC_RUN;
    endcase
    s_d.halted = (s_d.pwr != MIC_RUN);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_q <= '0;
      s_q.control <= `MIC_RST_CONTROL;
      s_q.pflag <= `MIC_RST_PFLAG;
      s_q.penable <= `MIC_RST_PENABLE;
      s_q.option <= `MIC_RST_OPTION;
      s_q.osc <= MIC_OSC_INT_RC;
      s_q.pwr <= MIC_RUN;
      s_q.waitrequest <= 1'b1;
      s_q.pc_vector <= `MIC_VECTOR_ADDR;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign avs_readdata = s_q.readdata;
  assign avs_waitrequest = s_q.waitrequest;
  assign irq_request = s_q.irq_request;
  assign vector_take = s_q.vector_take;
  assign push_stack = s_q.push_stack;
  assign pc_load = s_q.pc_load;
  assign pc_vector = s_q.pc_vector;
  assign core_wake = s_q.core_wake;
  assign halted = s_q.halted;
endmodule

//--- verification/mic_sva.sv
`timescale 1ns/1ns
module mic_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // core sequencer
  input wire logic irq_request,
  input wire logic vector_take,
  input wire logic push_stack,
  input wire logic pc_load,
  input wire logic [12:0] pc_vector,
  input wire logic core_wake,
  input wire logic halted
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_take;
    vector_take && push_stack && pc_load;
  endsequence
  chk_take_trio: assert property (vector_take |-> s_take)
    else $error("entry pulses not together");
  chk_vec_addr: assert property (pc_load |-> pc_vector == 13'h0004)
    else $error("wrong vector address");
  chk_take_req: assert property (vector_take |-> $past(irq_request) && !irq_request)
    else $error("entry without pending request");
  // global enable is cleared on entry, so no second entry can follow at once
  chk_take_once: assert property (s_take |=> !vector_take [*3])
    else $error("entry repeated");
  chk_halt_take: assert property (halted |-> !vector_take)
    else $error("entry while halted");
  chk_halt_req: assert property (halted && $past(halted) |-> !irq_request)
    else $error("request while halted");
  chk_wake_exit: assert property (core_wake |-> $past(halted) && !halted)
    else $error("wake not from halt");
  chk_bus_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus answer late");
endmodule

//--- verification/mic_core_model.sv
`timescale 1ns/1ns
module mic_core_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // controller and bench side
  input wire logic vector_take,
  input wire logic auto_rfi,
  output logic return_from_irq
);
  logic [3:0] svc_q;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      svc_q <= 4'h0;
      return_from_irq <= 1'b0;
    end
    else
    begin
      // short service routine that never clears the flag, then the return
      return_from_irq <= auto_rfi && svc_q == 4'h1;
      svc_q <= vector_take ? 4'hC : ((svc_q != 4'h0) ? svc_q - 4'h1 : 4'h0);
    end
  end
endmodule

//--- verification/mic_irq_ctrl_tb.sv
`timescale 1ns/1ns
module mic_irq_ctrl_tb;
  import mic_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, halt_enter = 1'b0;
  logic timer_overflow = 1'b0, conversion_done = 1'b0, ext_irq_pin = 1'b0, auto_rfi = 1'b1;
  logic port_pin_zero = 1'b0, port_pin_one = 1'b0, port_pin_three = 1'b0, return_from_irq;
  logic avs_waitrequest, irq_request, vector_take, push_stack, pc_load, core_wake, halted;
  logic [4:0] avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [12:0] pc_vector;
  logic [7:0] osc [3] = '{8'h03, 8'h01, 8'h04};
  logic [7:0] ctl [3] = '{8'h10, 8'h10, 8'h90};
  int errors = 0, cmp_count = 0, n;
  always #25 clk_sys = ~clk_sys;
  mic_irq_ctrl dut (.clk_sys, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .timer_overflow, .conversion_done,
    .ext_irq_pin, .port_pin_zero, .port_pin_one, .port_pin_three, .return_from_irq, .halt_enter,
    .irq_request, .vector_take, .push_stack, .pc_load, .pc_vector, .core_wake, .halted);
  mic_core_model core (.clk_sys, .rst, .vector_take, .auto_rfi, .return_from_irq);
  task automatic print_verdict;
    if (errors == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      errors++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask
  // s: 0 entry, 1 wake, 2 bus answer
  task automatic wait_for(input int s, input int lim, input logic must);
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while ((s == 2 ? !avs_waitrequest : s == 1 ? core_wake : vector_take) !== 1'b1 && n < lim);
    if (must && n >= lim)
    begin
      errors++;
      print_verdict;
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    wait_for(2, 20, 1'b1);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00);
    chk(nm, avs_readdata, {24'h000000, e});
  endtask
  task automatic sc_flags;
    bus(1'b1, 5'h00, 8'h38);
    @(posedge clk_sys);
    timer_overflow <= 1'b1;
    conversion_done <= 1'b1;
    ext_irq_pin <= 1'b1;
    port_pin_three <= 1'b1;
    @(posedge clk_sys);
    timer_overflow <= 1'b0;
    conversion_done <= 1'b0;
    wait_for(0, 10, 1'b0);
    chk("masked", n, 10);
    rdc("flags", 5'h00, 8'h3F);
    rdc("pflag", 5'h04, 8'h01);
    bus(1'b1, 5'h0C, 8'h00);
    bus(1'b1, 5'h00, 8'h00);
    ext_irq_pin <= 1'b0;
    port_pin_zero <= 1'b1;
    rdc("fall", 5'h00, 8'h03);
    bus(1'b1, 5'h00, 8'h00);
    ext_irq_pin <= 1'b1;
    port_pin_one <= 1'b1;
    rdc("rise_off", 5'h00, 8'h01);
    bus(1'b1, 5'h0C, 8'h40);
  endtask
  task automatic sc_vector;
    bus(1'b1, 5'h00, 8'hA0);
    @(posedge clk_sys);
    timer_overflow <= 1'b1;
    @(posedge clk_sys);
    timer_overflow <= 1'b0;
    wait_for(0, 20, 1'b1);
    chk("latency", n, 4);
    rdc("ctl_taken", 5'h00, 8'h24);
    // flag left set, so the return re-enables and re-enters
    wait_for(0, 40, 1'b1);
    auto_rfi <= 1'b0;
    chk("retake", vector_take, 1'b1);
    bus(1'b1, 5'h08, 8'h01);
    bus(1'b1, 5'h00, 8'h80);
    wait_for(0, 10, 1'b0);
    chk("no_group", n, 10);
    bus(1'b1, 5'h00, 8'hC0);
    wait_for(0, 10, 1'b1);
    chk("group_take", vector_take, 1'b1);
  endtask
  task automatic sc_halt;
    for (int i = 0; i < 3; i++)
    begin
      bus(1'b1, 5'h10, osc[i]);
      bus(1'b1, 5'h00, ctl[i]);
      @(posedge clk_sys);
      ext_irq_pin <= 1'b0;
      halt_enter <= 1'b1;
      @(posedge clk_sys);
      halt_enter <= 1'b0;
      @(posedge clk_sys);
      chk("halted", halted, 1'b1);
      ext_irq_pin <= 1'b1;
      wait_for(1, 300, 1'b1);
      chk("start_delay", n > 200, i == 1);
      wait_for(0, 8, i == 2);
      chk("after_wake", vector_take, i == 2);
    end
  endtask
  initial
  begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    chk("vector", {19'h0, pc_vector}, 32'h4);
    rdc("ctl_reset", 5'h00, 8'h00);
    rdc("unmapped", 5'h1C, 8'h00);
    sc_flags;
    sc_vector;
    sc_halt;
    bus(1'b1, 5'h10, 8'h07);
    rdc("osc_keep", 5'h10, 8'h04);
    print_verdict;
  end
endmodule
bind mic_irq_ctrl mic_sva chk_i (.clk_sys, .rst, .avs_read, .avs_write, .avs_waitrequest,
  .irq_request, .vector_take, .push_stack, .pc_load, .pc_vector, .core_wake, .halted);
